// *** hdl/pod_params.svh ***
`ifndef POD_PARAMS_SVH
`define POD_PARAMS_SVH
// device code tens digit classes
`define POD_CLS_APR_TEXT   4'h1
`define POD_CLS_APR_CSV    4'h2
`define POD_CLS_APR_BIN    4'h3
`define POD_CLS_PPR_TEXT   4'h4
`define POD_CLS_PPR_CSV    4'h5
`define POD_CLS_PPR_BIN    4'h6
`define POD_CLS_MODULE     4'h7
`define POD_CLS_COPY       4'h8
// copy sub codes
`define POD_COPY_NEW       4'h0
`define POD_COPY_ALL       4'h1
// baud digit limit
`define POD_BAUD_MAX       4'h3
// storage module universal address
`define POD_ADDR_UNIV      4'h1
`define POD_ADDR_MAX       4'h8
// queue depth
`define POD_QDEPTH         4
// ram block length in words (abort granularity)
`define POD_BLOCK_LEN      8'h10
`endif

// *** hdl/pod_pkg.sv ***
package pod_pkg;
    typedef enum logic [2:0] {
        POD_DEV_APR   = 3'h0,
        POD_DEV_PPR   = 3'h1,
        POD_DEV_MOD   = 3'h2,
        POD_DEV_MARK  = 3'h3,
        POD_DEV_COPYN = 3'h4,
        POD_DEV_COPYA = 3'h5
    } pod_dev_e;
    typedef struct packed {
        pod_dev_e    dev;
        logic [1:0]  fmt;    // 0 text,1 csv,2 binary
        logic [1:0]  baud;   // 0 300,1 1200,2 9600,3 76800
        logic [3:0]  addr;   // module address 1..8
        logic        area;   // 0 area1, 1 area2
    } pod_req_s;
    typedef struct packed {
        logic        start;  // one-cycle launch
        pod_req_s    req;
        logic [15:0] first;
        logic [15:0] last;
    } pod_xfer_s;
endpackage : pod_pkg

// *** hdl/pod_code_decode.sv ***
`timescale 1ns/1ps
`include "pod_params.svh"
module pod_code_decode
    import pod_pkg::*;
(
    input  wire logic [7:0] i_code,      // two bcd digits
    input  wire logic       i_area,      // active area
    input  wire logic       i_online,    // online instruction source
    output pod_req_s        o_req,       // decoded request
    output logic            o_valid      // code legal
);
    logic [3:0] tens;
    logic [3:0] ones;
    assign tens = i_code[7:4];
    assign ones = i_code[3:0];

    // tens selects device class, ones is baud, address or copy sub code
    always_comb begin
        o_req      = '0;
        o_req.area = i_area;
        o_valid    = 1'b0;
        case (tens)
            `POD_CLS_APR_TEXT, `POD_CLS_APR_CSV, `POD_CLS_APR_BIN: begin
                o_req.dev  = POD_DEV_APR;
                o_req.fmt  = 2'(tens - `POD_CLS_APR_TEXT);
                o_req.baud = ones[1:0];
                o_valid    = (ones <= `POD_BAUD_MAX);
            end
            `POD_CLS_PPR_TEXT, `POD_CLS_PPR_CSV, `POD_CLS_PPR_BIN: begin
                o_req.dev  = POD_DEV_PPR;
                o_req.fmt  = 2'(tens - `POD_CLS_PPR_TEXT);
                o_req.baud = ones[1:0];
                o_valid    = (ones <= `POD_BAUD_MAX);
            end
            `POD_CLS_MODULE: begin
                // ones 1..8 data, 9 is file mark to universal module
                if (ones >= `POD_ADDR_UNIV && ones <= `POD_ADDR_MAX) begin
                    o_req.dev  = POD_DEV_MOD;
                    o_req.addr = ones;
                    o_valid    = 1'b1;
                end else if (ones == 4'h9) begin
                    o_req.dev  = POD_DEV_MARK;
                    o_req.addr = `POD_ADDR_UNIV;
                    o_valid    = 1'b1;
                end
            end
            `POD_CLS_COPY: begin
                // copy codes only from the online instruction
                if (ones == `POD_COPY_NEW) begin
                    o_req.dev = POD_DEV_COPYN;
                    o_valid   = i_online;
                end else if (ones == `POD_COPY_ALL) begin
                    o_req.dev = POD_DEV_COPYA;
                    o_valid   = i_online;
                end
            end
            default: o_valid = 1'b0;
        endcase
    end
endmodule : pod_code_decode

// *** hdl/pod_dispatch.sv ***
`timescale 1ns/1ps
`include "pod_params.svh"
module pod_dispatch
    import pod_pkg::*;
#(
    parameter int QDEPTH = `POD_QDEPTH
) (
    input  wire logic        i_clk,           // 100 mhz clock
    input  wire logic        i_rst_n,         // async reset, active low
    input  wire logic        i_table_start,   // program table pass begins
    input  wire logic        i_area_set,      // set active area
    input  wire logic        i_area_sel,      // 0 area1, 1 area2
    input  wire logic        i_req,           // online output request pulse
    input  wire logic [7:0]  i_code,          // bcd device code
    input  wire logic        i_conn_busy,     // connector used by other io
    input  wire logic [15:0] i_newest_ptr,    // newest-data pointer
    input  wire logic [7:0]  i_mod_present,   // module present per address
    input  wire logic        i_area2_alloc,   // area 2 has memory
    input  wire logic        i_dump_go,       // manual dump launch
    input  wire logic [7:0]  i_dump_code,     // manual dump device code
    input  wire logic        i_dump_area,     // operator area choice
    input  wire logic        i_start_ovr,     // operator start override valid
    input  wire logic [15:0] i_start_loc,     // operator start
    input  wire logic        i_end_ovr,       // operator end override valid
    input  wire logic [15:0] i_end_loc,       // operator end
    input  wire logic        i_key,           // keypress
    input  wire logic        i_word_ack,      // peripheral took a word
    output logic             o_req_taken,     // request queued
    output logic             o_req_reject,    // duplicate, illegal or queue full
    output logic             o_sync_en,       // sync device enable line
    output logic             o_modem_pin,     // pin-enabled modem pin
    output logic [3:0]       o_mod_addr,      // addressed module
    output logic             o_mod_sel,       // module addressing active
    output logic             o_mark,          // file mark command
    output logic             o_copy,          // area copy active
    output logic [1:0]       o_fmt,           // printer format
    output logic [1:0]       o_baud,          // baud code
    output logic             o_word_req,      // word out valid
    output logic [15:0]      o_loc,           // current location
    output logic             o_src_area,      // area being read
    output logic             o_busy,          // dispatcher transferring
    output logic             o_dump_step_area // dump shows area step
);
    typedef enum logic [2:0] {
        POD_ST_IDLE  = 3'h0,
        POD_ST_PICK  = 3'h1,
        POD_ST_SEND  = 3'h2,
        POD_ST_DONE  = 3'h3
    } pod_state_e;

    localparam int QW = $clog2(QDEPTH);

    // lowest present module address, 0 when none
    function automatic logic [3:0] pod_lowest(input logic [7:0] pres);
        logic [3:0] a;
        a = 4'h0;
        for (int k = 7; k >= 0; k--) begin
            if (pres[k]) a = 4'(k + 1);
        end
        return a;
    endfunction : pod_lowest

    // key that identifies a queue entry
    function automatic logic [9:0] pod_key(input pod_req_s r);
        return {r.dev, r.baud, r.addr, r.area};
    endfunction : pod_key

    // pin inputs through two flops
    // busy resets high: no queue launch before the pin is seen
    logic [7:0] pres_m_q, pres_q;
    logic       busy_m_q, busy_q, key_m_q, key_q, ack_m_q, ack_q;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pres_m_q <= 8'h00;
            pres_q   <= 8'h00;
            busy_m_q <= 1'b1;
            busy_q   <= 1'b1;
            key_m_q  <= 1'b0;
            key_q    <= 1'b0;
            ack_m_q  <= 1'b0;
            ack_q    <= 1'b0;
        end else begin
            pres_m_q <= i_mod_present;
            pres_q   <= pres_m_q;
            busy_m_q <= i_conn_busy;
            busy_q   <= busy_m_q;
            key_m_q  <= i_key;
            key_q    <= key_m_q;
            ack_m_q  <= i_word_ack;
            ack_q    <= ack_m_q;
        end
    end

    // active area, back to area 1 on every table pass
    // table start beats a set in the same cycle
    logic area_q;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) area_q <= 1'b0;
        else if (i_table_start) area_q <= 1'b0;
        else if (i_area_set) area_q <= i_area_sel;
    end

    pod_req_s dec_req;
    logic     dec_ok;
    pod_code_decode u_dec (
        .i_code   (i_code),
        .i_area   (area_q),
        .i_online (1'b1),
        .o_req    (dec_req),
        .o_valid  (dec_ok)
    );
    pod_req_s dmp_req;
    logic     dmp_ok;
    logic     dmp_area;
    // no area 2 memory: area step skipped, area 1 used
    assign dmp_area = i_area2_alloc ? i_dump_area : 1'b0;
    // the dump decoder refuses copy codes
    pod_code_decode u_dmp (
        .i_code   (i_dump_code),
        .i_area   (dmp_area),
        .i_online (1'b0),
        .o_req    (dmp_req),
        .o_valid  (dmp_ok)
    );

    // fifo queue in acceptance order
    // pointers carry a wrap bit so full and empty differ
    pod_req_s     q_mem [QDEPTH];
    logic [QW:0]  q_wr_q, q_rd_q;
    logic         dup, q_full, q_empty, push, pop;
    assign q_full  = (q_wr_q - q_rd_q) == (QW+1)'(QDEPTH);
    assign q_empty = (q_wr_q == q_rd_q);
    // slot k is live when its distance from the read slot is
    // below the fill, taken in slot width to survive wraps
    always_comb begin
        dup = 1'b0;
        for (int k = 0; k < QDEPTH; k++) begin
            if ({1'b0, QW'(k) - q_rd_q[QW-1:0]} < (q_wr_q - q_rd_q) &&
                pod_key(q_mem[k]) == pod_key(dec_req)) dup = 1'b1;
        end
    end
    // a full queue refuses, the program never stalls
    assign push = i_req && dec_ok && !dup && !q_full;

    // queue write side; request never stalls the program
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q_wr_q <= '0;
            for (int k = 0; k < QDEPTH; k++) q_mem[k] <= '0;
        end else if (push) begin
            q_mem[q_wr_q[QW-1:0]] <= dec_req;
            q_wr_q <= q_wr_q + 1'b1;
        end
    end
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) q_rd_q <= '0;
        else if (pop) q_rd_q <= q_rd_q + 1'b1;
    end
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_req_taken  <= 1'b0;
            o_req_reject <= 1'b0;
        end else begin
            o_req_taken  <= push;
            o_req_reject <= i_req && !push;
        end
    end

    // per-device last-sent pointers: print pointer, module pointer and copy pointer
    // one set per area; printers share the print pointer
    logic [15:0] print_pointer_q [2];
    logic [15:0] module_pointer_q [2];
    logic [15:0] copy_pointer_q [2];

    // transfer engine
    pod_state_e  st_q;
    pod_req_s    cur_q;
    logic [15:0] loc_q, end_q;
    logic [7:0]  blk_q;
    logic        manual_q, abort_q, adv_ok_q;
    logic [3:0]  res_addr;
    logic        mod_dev, cur_mod;
    // universal address uses the synchronised presence map
    assign mod_dev  = (cur_q.dev == POD_DEV_MOD) || (cur_q.dev == POD_DEV_MARK);
    assign res_addr = (cur_q.addr == `POD_ADDR_UNIV) ? pod_lowest(pres_q)
                                                     : cur_q.addr;
    assign cur_mod  = (res_addr != 4'h0) && pres_q[3'(res_addr - 4'h1)];
    // a manual dump wins a tie with the queue
    assign pop      = (st_q == POD_ST_IDLE) && !busy_q && !q_empty && !i_dump_go;

    function automatic logic [15:0] pod_start(input pod_req_s r);
        case (r.dev)
            POD_DEV_APR, POD_DEV_PPR: return print_pointer_q[r.area];
            POD_DEV_MOD, POD_DEV_MARK: return module_pointer_q[r.area];
            POD_DEV_COPYN: return copy_pointer_q[r.area];
            default: return 16'h0000;
        endcase
    endfunction : pod_start

    // state sequence: pick entry, resolve, send words, retire
    // end frozen at pick: newer data waits its next turn
    // a keyed start past the end runs until the count wraps
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q     <= POD_ST_IDLE;
            cur_q    <= '0;
            loc_q    <= 16'h0000;
            end_q    <= 16'h0000;
            blk_q    <= 8'h00;
            manual_q <= 1'b0;
            abort_q  <= 1'b0;
            adv_ok_q <= 1'b0;
        end else begin
            case (st_q)
                POD_ST_IDLE: begin
                    abort_q <= 1'b0;
                    if (i_dump_go && dmp_ok) begin
                        cur_q    <= dmp_req;
                        manual_q <= 1'b1;
                        loc_q    <= i_start_ovr ? i_start_loc : pod_start(dmp_req);
                        end_q    <= i_end_ovr ? i_end_loc : i_newest_ptr;
                        st_q     <= POD_ST_PICK;
                    end else if (pop) begin
                        cur_q    <= q_mem[q_rd_q[QW-1:0]];
                        manual_q <= 1'b0;
                        loc_q    <= (q_mem[q_rd_q[QW-1:0]].dev == POD_DEV_COPYA) ?
                                    16'h0000 : pod_start(q_mem[q_rd_q[QW-1:0]]);
                        end_q    <= i_newest_ptr;
                        st_q     <= POD_ST_PICK;
                    end
                end
                POD_ST_PICK: begin
                    blk_q <= 8'h00;
                    if (mod_dev && !cur_mod) begin
                        adv_ok_q <= 1'b0;
                        st_q     <= POD_ST_IDLE;
                    end else begin
                        adv_ok_q <= 1'b1;
                        st_q     <= (cur_q.dev == POD_DEV_MARK || loc_q == end_q) ?
                                    POD_ST_DONE : POD_ST_SEND;
                    end
                end
                POD_ST_SEND: begin
                    // a key only latches; the block edge stops
                    // blocks count from the dump start
                    if (key_q && manual_q) abort_q <= 1'b1;
                    if (ack_q) begin
                        loc_q <= loc_q + 16'h0001;
                        blk_q <= (blk_q == `POD_BLOCK_LEN - 8'h01) ? 8'h00 : blk_q + 8'h01;
                        if (loc_q + 16'h0001 == end_q) st_q <= POD_ST_DONE;
                        else if ((abort_q || (key_q && manual_q)) &&
                                 blk_q == `POD_BLOCK_LEN - 8'h01)
                            st_q <= POD_ST_DONE;
                    end
                end
                // one cycle here for pointer update and mark
                POD_ST_DONE: st_q <= POD_ST_IDLE;
                default: st_q <= POD_ST_IDLE;
            endcase
        end
    end

    // pointer advance only after a real transfer
    // manual dumps leave pointers for online output
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            print_pointer_q[0]  <= 16'h0000;
            print_pointer_q[1]  <= 16'h0000;
            module_pointer_q[0] <= 16'h0000;
            module_pointer_q[1] <= 16'h0000;
            copy_pointer_q[0]   <= 16'h0000;
            copy_pointer_q[1]   <= 16'h0000;
        end else if (st_q == POD_ST_DONE && adv_ok_q && !manual_q) begin
            case (cur_q.dev)
                POD_DEV_APR, POD_DEV_PPR: print_pointer_q[cur_q.area] <= loc_q;
                POD_DEV_MOD: module_pointer_q[cur_q.area] <= loc_q;
                POD_DEV_COPYN, POD_DEV_COPYA: copy_pointer_q[cur_q.area] <= loc_q;
                default: copy_pointer_q[cur_q.area] <= copy_pointer_q[cur_q.area];
            endcase
        end
    end

    // peripheral selection outputs, all registered
    // done counts as active to cover the last word
    logic active;
    assign active = (st_q == POD_ST_SEND) || (st_q == POD_ST_DONE && adv_ok_q);
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_sync_en        <= 1'b0;
            o_modem_pin      <= 1'b0;
            o_mod_addr       <= 4'h0;
            o_mod_sel        <= 1'b0;
            o_mark           <= 1'b0;
            o_copy           <= 1'b0;
            o_fmt            <= 2'h0;
            o_baud           <= 2'h0;
            o_word_req       <= 1'b0;
            o_loc            <= 16'h0000;
            o_src_area       <= 1'b0;
            o_busy           <= 1'b0;
            o_dump_step_area <= 1'b0;
        end else begin
            o_sync_en   <= active && cur_q.dev == POD_DEV_PPR;
            // modem sits outside; its pin stays low
            o_modem_pin <= 1'b0;
            o_mod_addr  <= mod_dev ? res_addr : 4'h0;
            o_mod_sel   <= active && mod_dev;
            o_mark      <= st_q == POD_ST_DONE && adv_ok_q &&
                           cur_q.dev == POD_DEV_MARK;
            o_copy      <= active && (cur_q.dev == POD_DEV_COPYN ||
                                      cur_q.dev == POD_DEV_COPYA);
            o_fmt       <= cur_q.fmt;
            o_baud      <= cur_q.baud;
            o_word_req  <= st_q == POD_ST_SEND;
            o_loc       <= loc_q;
            o_src_area  <= cur_q.area;
            o_busy      <= st_q != POD_ST_IDLE;
            o_dump_step_area <= i_area2_alloc;
        end
    end
endmodule : pod_dispatch

// *** test/pod_checker.sv ***
`timescale 1ns/1ps
module pod_checker (
    input wire logic        i_clk,            // clock
    input wire logic        i_rst_n,          // reset
    input wire logic        i_req,            // request
    input wire logic [7:0]  i_mod_present,    // modules
    input wire logic        i_area2_alloc,    // area 2
    input wire logic        o_req_taken,      // queued
    input wire logic        o_req_reject,     // refused
    input wire logic        o_modem_pin,      // modem pin
    input wire logic [3:0]  o_mod_addr,       // module
    input wire logic        o_mod_sel,        // addressing
    input wire logic        o_mark,           // file mark
    input wire logic [1:0]  o_fmt,            // format
    input wire logic [1:0]  o_baud,           // baud
    input wire logic        o_sync_en,        // print enable
    input wire logic        o_word_req,       // word valid
    input wire logic [15:0] o_loc,            // location
    input wire logic        o_busy,           // transferring
    input wire logic        o_dump_step_area  // area step
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // one answer per request, on the next edge
    a_req_answer: assert property (i_req |=> o_req_taken != o_req_reject)
        else $error("request not answered once");
    a_taken_cause: assert property (o_req_taken |-> $past(i_req))
        else $error("taken without request");
    a_modem_quiet: assert property (o_modem_pin == 1'b0)
        else $error("modem pin driven");
    // words flow only while the dispatcher owns the connector
    a_word_busy: assert property (o_word_req |-> o_busy)
        else $error("word outside transfer");
    // display moves only around a transfer, frozen once done
    a_loc_busy: assert property ($changed(o_loc) |->
        (o_busy || $past(o_busy) || $past(o_busy, 2)) or (##[1:3] o_busy))
        else $error("location moved while idle");
    a_print_hold: assert property (o_sync_en && $past(o_sync_en) |->
        $stable({o_fmt, o_baud}))
        else $error("print settings changed mid transfer");
    a_mark_pulse: assert property (o_mark |=> !o_mark)
        else $error("file mark held");
    a_mod_present: assert property (o_word_req && o_mod_sel && o_mod_addr != 4'h0 |->
        i_mod_present[3'(o_mod_addr - 4'h1)])
        else $error("data sent to absent module");
    a_area_step: assert property (i_area2_alloc |-> ##[0:3] o_dump_step_area)
        else $error("area step not offered");
    c_queued: cover property (o_req_taken && !o_busy);
    c_pin_print: cover property (o_sync_en && o_word_req);
    c_file_mark: cover property (o_mark);
endmodule : pod_checker

bind pod_dispatch pod_checker pod_checker_inst (.*);

// *** test/pod_periph.sv ***
`timescale 1ns/1ps
module pod_periph (
    input wire logic       i_clk,      // clock
    input wire logic       i_rst_n,    // reset
    input wire logic       i_word_req, // word offered
    input wire logic       i_en,       // selected
    input wire logic [3:0] i_delay,    // extra wait per word
    output logic           o_ack,      // word taken
    output int             o_words     // words taken
);
    logic [3:0] wait_q;
    logic [2:0] gap_q;
    // gap covers ack sync plus location update, else one word is taken twice
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_ack <= 1'b0;
            wait_q <= 4'h0;
            gap_q <= 3'h0;
            o_words <= 0;
        end else begin
            o_ack <= 1'b0;
            if (gap_q != 3'h0) begin
                gap_q <= gap_q - 3'h1;
            end else if (i_word_req && i_en) begin
                wait_q <= wait_q + 4'h1;
                if (wait_q >= i_delay) begin
                    o_ack <= 1'b1;
                    wait_q <= 4'h0;
                    gap_q <= 3'h6;
                    o_words <= o_words + 1;
                end
            end
        end
    end
endmodule : pod_periph

// *** test/pod_dispatch_tb.sv ***
`timescale 1ns/1ps
module pod_dispatch_tb;
    logic i_clk, i_rst_n, i_table_start, i_area_set, i_area_sel, i_req, i_conn_busy, i_key;
    logic i_area2_alloc, i_dump_go, i_dump_area, i_start_ovr, i_end_ovr, i_word_ack, o_copy;
    logic o_req_taken, o_req_reject, o_sync_en, o_modem_pin, o_mod_sel, o_mark, o_busy;
    logic o_word_req, o_src_area, o_dump_step_area;
    logic [1:0] o_fmt, o_baud;
    logic [3:0] o_mod_addr, delay;
    logic [7:0] i_code, i_mod_present, i_dump_code;
    logic [15:0] i_newest_ptr, i_start_loc, i_end_loc, o_loc, e;
    int failures, check_count, words, marks, n;

    pod_dispatch #(.QDEPTH(4)) pod_dispatch_inst (.*);
    // a single far-side device, so never two modems
    pod_periph pod_periph_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_word_req(o_word_req),
        .i_en(o_busy), .i_delay(delay), .o_ack(i_word_ack), .o_words(words));

    always #5 i_clk = ~i_clk;
    always @(posedge i_clk) if (o_mark === 1'b1) marks++;

    task automatic finish_test();
        if (failures == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : finish_test
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            failures++;
        end
    endtask : check
    task automatic expire(input string what);
        check(what, 16'h1, 16'h0);
        finish_test();
    endtask : expire
    task automatic tick(input int k = 1);
        repeat (k) @(posedge i_clk);
        #1;
    endtask : tick
    task automatic wait_word();
        for (n = 0; n < 300 && o_word_req !== 1'b1; n++) tick();
        if (n == 300) expire("word start");
    endtask : wait_word
    task automatic idle();
        for (n = 0; n < 3000 && o_busy !== 1'b0; n++) tick();
        if (n == 3000) expire("transfer end");
    endtask : idle
    task automatic send(input logic [7:0] code, input logic ok);
        i_code = code;
        i_req = 1'b1;
        tick();
        i_req = 1'b0;
        check("taken", {15'h0, ok}, {15'h0, o_req_taken});
        check("reject", {15'h0, !ok}, {15'h0, o_req_reject});
        tick();
    endtask : send
    // expected select fields: area, print enable, module select, address, format, baud
    function automatic logic [15:0] exp_cap(input logic [7:0] c, input logic a);
        if (c[7:4] == 4'h7) return {5'h0, a, 2'b01, (c[3:0] == 4'h1) ? 4'h3 : c[3:0], 4'h0};
        return {5'h0, a, c[7:4] >= 4'h4, 5'h0, 2'((c[7:4] - 4'h1) % 3), c[1:0]};
    endfunction : exp_cap
    // newest pointer moves on after the pick, so the end must be the old value
    task automatic serve(input logic [7:0] code, input logic area);
        logic [15:0] m;
        m = (code[7:4] == 4'h7) ? 16'h05F0 : 16'h060F;
        e = i_newest_ptr;
        wait_word();
        i_newest_ptr = e + 16'h3;
        check("select", exp_cap(code, area) & m, {5'h0, o_src_area, o_sync_en, o_mod_sel,
            o_mod_addr, o_fmt, o_baud} & m);
        idle();
        check("end location", e, o_loc);
    endtask : serve
    task automatic s_codes();
        logic [7:0] c [10] = '{8'h10, 8'h21, 8'h32, 8'h43, 8'h50, 8'h61, 8'h62, 8'h73,
            8'h71, 8'h33};
        foreach (c[k]) begin
            send(c[k], 1'b1);
            serve(c[k], 1'b0);
        end
    endtask : s_codes
    // copy codes: whole area from 0, then only the new part; refused in a dump
    task automatic s_copy();
        e = i_newest_ptr;
        send(8'h81, 1'b1);
        wait_word();
        check("copy all", 16'h1, {15'h0, o_copy});
        check("copy start", 16'h0, o_loc);
        idle();
        i_newest_ptr = e + 16'h2;
        send(8'h80, 1'b1);
        wait_word();
        check("copy new", e, o_loc);
        idle();
        check("copy end", e + 16'h2, o_loc);
        {i_dump_code, i_dump_go} = {8'h80, 1'b1};
        tick();
        i_dump_go = 1'b0;
        tick(4);
        check("dump copy", 16'h0, {15'h0, o_busy});
    endtask : s_copy
    // busy connector: queue fills, duplicate and overflow refused, served in order
    task automatic s_queue();
        i_conn_busy = 1'b1;
        tick(3);
        send(8'h10, 1'b1);
        send(8'h10, 1'b0);
        send(8'h11, 1'b1);
        send(8'h73, 1'b1);
        send(8'h42, 1'b1);
        send(8'h43, 1'b0);
        check("held", 16'h0, {15'h0, o_busy});
        delay = 4'h3;
        i_conn_busy = 1'b0;
        serve(8'h10, 1'b0);
        serve(8'h11, 1'b0);
        serve(8'h73, 1'b0);
        serve(8'h42, 1'b0);
        delay = 4'h0;
    endtask : s_queue
    task automatic s_module();
        e = 16'(words);
        send(8'h75, 1'b1);
        tick(60);
        check("absent words", e, 16'(words));
        e = 16'(marks);
        send(8'h79, 1'b1);
        for (n = 0; n < 100 && 16'(marks) == e; n++) tick();
        check("file mark", e + 16'h1, 16'(marks));
        idle();
    endtask : s_module
    task automatic s_area();
        i_area_sel = 1'b1;
        i_area_set = 1'b1;
        tick();
        i_area_set = 1'b0;
        send(8'h52, 1'b1);
        serve(8'h52, 1'b1);
        i_table_start = 1'b1;
        tick();
        i_table_start = 1'b0;
        send(8'h53, 1'b1);
        serve(8'h53, 1'b0);
    endtask : s_area
    task automatic dump(input logic ovr);
        {i_start_ovr, i_end_ovr} = {ovr, ovr};
        i_dump_go = 1'b1;
        tick();
        i_dump_go = 1'b0;
        wait_word();
    endtask : dump
    // operator limits, then a key mid-block, then the default limits
    task automatic s_dump();
        check("area step", 16'h1, {15'h0, o_dump_step_area});
        {i_dump_code, i_start_loc, i_end_loc} = {8'h73, 16'h0010, 16'h0040};
        dump(1'b1);
        check("dump start", 16'h0010, o_loc);
        i_key = 1'b1;
        tick(3);
        i_key = 1'b0;
        idle();
        check("dump abort", 16'h0020, o_loc);
        e = o_loc;
        tick(20);
        check("dump held", e, o_loc);
        dump(1'b0);
        idle();
        check("dump end", i_newest_ptr, o_loc);
        {i_area2_alloc, i_dump_area, i_end_loc} = {1'b0, 1'b1, 16'h0014};
        dump(1'b1);
        check("area skip", 16'h0, {14'h0, o_dump_step_area, o_src_area});
        idle();
        i_area2_alloc = 1'b1;
        dump(1'b1);
        check("area pick", 16'h3, {14'h0, o_dump_step_area, o_src_area});
        idle();
    endtask : s_dump

    initial begin
        {i_clk, i_rst_n, i_table_start, i_area_set, i_area_sel, i_req, i_conn_busy} = '0;
        {i_dump_go, i_dump_area, i_start_ovr, i_end_ovr, i_key, i_code, i_dump_code} = '0;
        {i_start_loc, i_end_loc, delay, failures, check_count, marks} = '0;
        {i_area2_alloc, i_mod_present, i_newest_ptr} = {1'b1, 8'h04, 16'h0003};
        repeat (4) @(posedge i_clk);
        #1;
        i_rst_n = 1'b1;
        s_codes();
        s_copy();
        s_queue();
        s_module();
        s_area();
        s_dump();
        finish_test();
    end
endmodule : pod_dispatch_tb
